// file: pwk_ctrl.sv
`timescale 1ns/1ps
`include "pwk_defs.svh"
module pwk_ctrl
    import pwk_pkg::*;
(
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [11:0]   awaddr,
    input  wire logic          awvalid,
    output logic               awready,
    input  wire logic [31:0]   wdata,
    input  wire logic [3:0]    wstrb,
    input  wire logic          wvalid,
    output logic               wready,
    output logic [1:0]         bresp,
    output logic               bvalid,
    input  wire logic          bready,
    input  wire logic [11:0]   araddr,
    input  wire logic          arvalid,
    output logic               arready,
    output logic [31:0]        rdata,
    output logic [1:0]         rresp,
    output logic               rvalid,
    input  wire logic          rready,
    input  wire logic [7:0]    porta_pin,
    input  wire logic          touch_request_n,
    input  wire logic          capture_pin,
    input  wire logic          osc_clock_pin,
    input  wire pwk_event_type events,
    input  wire logic          sleep_instruction,
    input  wire logic          irq_ack,
    output logic               irq_req,
    output logic [19:0]        irq_vector,
    output logic               core_run,
    output logic               pll_select
);

    pwk_state_type q;
    pwk_state_type next;

    logic touch_active;
    logic pend_l1;
    logic pend_l2;
    logic pend_l3;
    logic pend_l4;
    logic pend_l5;
    logic dispatch_ok;
    logic wake_sleep;
    logic wake_idle;

    // returns {hit, index}; misaligned or unmapped words miss
    function automatic logic [8:0] addr_index(input logic [11:0] addr);
        logic [7:0] idx;
        logic       hit;
        idx = addr[9:2];
        hit = 1'b0;
        if (addr[1:0] == 2'h0 && addr[11:10] == 2'h0) begin
            case (idx)
                `PWK_IDX_CPU_MODE, `PWK_IDX_T2_RELOAD, `PWK_IDX_IRQ_EN,
                `PWK_IDX_IRQ_FLAGS, `PWK_IDX_T0_RELOAD_LO, `PWK_IDX_T0_RELOAD_HI,
                `PWK_IDX_T1_RELOAD, `PWK_IDX_PA_EN, `PWK_IDX_PA_FLAGS,
                `PWK_IDX_PA_WAKE, `PWK_IDX_SPI_STAT, `PWK_IDX_SPH_CTRL,
                `PWK_IDX_SPH_RELOAD, `PWK_IDX_WAKE_CTRL: hit = 1'b1;
                default: hit = 1'b0;
            endcase
        end
        return {hit, idx};
    endfunction

    assign touch_active = ~q.touch_s2 & q.wake_ctrl[`PWK_WK_TOUCH];
    assign pend_l1 = (|(q.pa_flags & q.pa_en)) | touch_active;
    assign pend_l2 = q.irq_flags[`PWK_IRQ_CAP] & q.irq_en[`PWK_IRQ_CAP];
    assign pend_l3 = q.sph_ctrl[`PWK_SPH_FLAG] & q.sph_ctrl[`PWK_SPH_EN];
    assign pend_l4 = |(q.irq_flags[2:0] & q.irq_en[2:0]);
    assign pend_l5 = (|(q.irq_flags[6:3] & q.irq_en[6:3]))
                   | (q.spi_stat[`PWK_SPI_FLAG] & q.spi_stat[`PWK_SPI_EN]);
    assign dispatch_ok = aresetn & ~q.irq_req & (q.mode == PWK_RUN)
                       & q.cpu_mode[`PWK_CM_GLOBAL];
    // port, touch, spi slave wake from sleep
    assign wake_sleep = (|(q.pa_flags & q.pa_wake)) | touch_active
                      | (q.wake_ctrl[`PWK_WK_SPI_SLAVE] & q.spi_stat[`PWK_SPI_WAKE]
                         & q.spi_stat[`PWK_SPI_FLAG]);
    // timer 1 and adc add to idle wake only
    assign wake_idle = wake_sleep
                     | (q.irq_flags[`PWK_IRQ_T1] & q.wake_ctrl[`PWK_WK_T1])
                     | (q.irq_flags[`PWK_IRQ_ADC] & q.wake_ctrl[`PWK_WK_ADC]);

    always_comb begin
        logic [8:0]  wdec;
        logic [8:0]  rdec;
        logic [7:0]  rbyte;
        logic [7:0]  pa_fall;
        logic        cap_rise;
        logic        cap_fall;
        logic        cap_end_rise;
        logic        osc_edge;
        logic [15:0] t0_word;
        wdec = 9'h000;
        rdec = 9'h000;
        rbyte = 8'h00;
        pa_fall = q.pa_s3 & ~q.pa_s2;
        cap_rise = q.cap_s2 & ~q.cap_s3;
        cap_fall = ~q.cap_s2 & q.cap_s3;
        osc_edge = q.osc_s2 & ~q.osc_s3;
        t0_word = {q.t0_hi, q.t0_lo};
        cap_end_rise = q.wake_ctrl[`PWK_WK_CAP_HI] ^ q.wake_ctrl[`PWK_WK_CAP_LO];
        next = q;

        // synchronisers, first stage feeds only the second
        next.pa_s1 = porta_pin;
        next.pa_s2 = q.pa_s1;
        next.pa_s3 = q.pa_s2;
        next.touch_s1 = touch_request_n;
        next.touch_s2 = q.touch_s1;
        next.cap_s1 = capture_pin;
        next.cap_s2 = q.cap_s1;
        next.cap_s3 = q.cap_s2;
        next.osc_s1 = osc_clock_pin;
        next.osc_s2 = q.osc_s1;
        next.osc_s3 = q.osc_s2;

        // write channel: address and data taken in either order
        if (q.awready && awvalid) begin
            next.awready = 1'b0;
            next.aw_held = 1'b1;
            next.aw_addr = awaddr;
        end
        if (q.wready && wvalid) begin
            next.wready = 1'b0;
            next.w_held = 1'b1;
            next.wbyte = wdata[7:0];
            next.wlane0 = wstrb[0];
        end
        if (q.aw_held && q.w_held && !q.bvalid) begin
            wdec = addr_index(q.aw_addr);
            next.bvalid = 1'b1;
            next.bresp = wdec[8] ? `PWK_RESP_OKAY : `PWK_RESP_SLVERR;
            if (wdec[8] && q.wlane0) begin
                case (wdec[7:0])
                    `PWK_IDX_CPU_MODE:     next.cpu_mode = q.wbyte & 8'h87;
                    `PWK_IDX_T2_RELOAD:    next.t2_reload = q.wbyte;
                    `PWK_IDX_IRQ_EN:       next.irq_en = q.wbyte;
                    `PWK_IDX_IRQ_FLAGS:    next.irq_flags = q.wbyte;
                    `PWK_IDX_T0_RELOAD_LO: next.t0_lo = q.wbyte;
                    `PWK_IDX_T0_RELOAD_HI: next.t0_hi = q.wbyte;
                    `PWK_IDX_T1_RELOAD:    next.t1_reload = q.wbyte;
                    `PWK_IDX_PA_EN:        next.pa_en = q.wbyte;
                    `PWK_IDX_PA_FLAGS:     next.pa_flags = q.wbyte;
                    `PWK_IDX_PA_WAKE:      next.pa_wake = q.wbyte;
                    `PWK_IDX_SPI_STAT:     next.spi_stat = q.wbyte & 8'h38;
                    `PWK_IDX_SPH_CTRL:     next.sph_ctrl = q.wbyte & 8'h37;
                    `PWK_IDX_SPH_RELOAD:   next.sph_reload = q.wbyte;
                    `PWK_IDX_WAKE_CTRL:    next.wake_ctrl = q.wbyte & 8'h3F;
                    default:               next.wake_ctrl = q.wake_ctrl;
                endcase
            end
        end
        if (q.bvalid && bready) begin
            next.bvalid = 1'b0;
            next.aw_held = 1'b0;
            next.w_held = 1'b0;
            next.awready = 1'b1;
            next.wready = 1'b1;
        end

        // read channel, one cycle to answer
        if (q.arready && arvalid) begin
            rdec = addr_index(araddr);
            case (rdec[7:0])
                `PWK_IDX_CPU_MODE:     rbyte = q.cpu_mode;
                `PWK_IDX_T2_RELOAD:    rbyte = q.t2_reload;
                `PWK_IDX_IRQ_EN:       rbyte = q.irq_en;
                `PWK_IDX_IRQ_FLAGS:    rbyte = q.irq_flags;
                `PWK_IDX_T0_RELOAD_LO: rbyte = q.t0_lo;
                `PWK_IDX_T0_RELOAD_HI: rbyte = q.t0_hi;
                `PWK_IDX_T1_RELOAD:    rbyte = q.t1_reload;
                `PWK_IDX_PA_EN:        rbyte = q.pa_en;
                `PWK_IDX_PA_FLAGS:     rbyte = q.pa_flags;
                `PWK_IDX_PA_WAKE:      rbyte = q.pa_wake;
                `PWK_IDX_SPI_STAT:     rbyte = q.spi_stat;
                `PWK_IDX_SPH_CTRL:     rbyte = q.sph_ctrl;
                `PWK_IDX_SPH_RELOAD:   rbyte = q.sph_reload;
                `PWK_IDX_WAKE_CTRL:    rbyte = q.wake_ctrl;
                default:               rbyte = 8'h00;
            endcase
            next.arready = 1'b0;
            next.rvalid = 1'b1;
            next.rdata = rdec[8] ? {24'h000000, rbyte} : 32'h00000000;
            next.rresp = rdec[8] ? `PWK_RESP_OKAY : `PWK_RESP_SLVERR;
        end
        if (q.rvalid && rready) begin
            next.rvalid = 1'b0;
            next.arready = 1'b1;
        end

        // hardware sets come after software writes so a set wins over a clear
        // port A falling edge
        next.pa_flags = next.pa_flags | pa_fall;
        if (cap_end_rise ? cap_rise : cap_fall) begin
            next.irq_flags[`PWK_IRQ_CAP] = 1'b1;
        end
        if (events.speech_tick) begin
            if (q.sph_count == 11'h000) begin
                next.sph_count = {q.sph_ctrl[2:0], q.sph_reload};
                next.sph_ctrl[`PWK_SPH_FLAG] = 1'b1;
            end else begin
                next.sph_count = q.sph_count - 11'h001;
            end
        end
        if (events.timer0_tick) begin
            if (q.t0_count > t0_word) begin
                next.t0_count = 16'h0000;
                next.irq_flags[`PWK_IRQ_T0] = 1'b1;
            end else begin
                next.t0_count = q.t0_count + 16'h0001;
            end
        end
        if (events.timer1_tick) begin
            if (q.t1_count == 8'h00) begin
                next.t1_count = q.t1_reload;
                next.irq_flags[`PWK_IRQ_T1] = 1'b1;
            end else begin
                next.t1_count = q.t1_count - 8'h01;
            end
        end
        if (events.timer2_tick) begin
            if (q.t2_count == 8'h00) begin
                next.t2_count = q.t2_reload;
                next.irq_flags[`PWK_IRQ_T2] = 1'b1;
            end else begin
                next.t2_count = q.t2_count - 8'h01;
            end
        end
        next.irq_flags[`PWK_IRQ_ADC] = next.irq_flags[`PWK_IRQ_ADC] | events.adc_done;
        next.irq_flags[`PWK_IRQ_UERR] = next.irq_flags[`PWK_IRQ_UERR] | events.uart_error;
        next.irq_flags[`PWK_IRQ_UTX] = next.irq_flags[`PWK_IRQ_UTX] | events.uart_tx_empty;
        next.irq_flags[`PWK_IRQ_URX] = next.irq_flags[`PWK_IRQ_URX] | events.uart_rx_full;
        // spi flag in its own status
        next.spi_stat[`PWK_SPI_FLAG] = next.spi_stat[`PWK_SPI_FLAG] | events.spi_rx_full;

        // acknowledge takes the request and drops global
        if (q.irq_req && irq_ack) begin
            next.irq_req = 1'b0;
            next.cpu_mode[`PWK_CM_GLOBAL] = 1'b0;
        end else if (dispatch_ok) begin
            next.irq_req = pend_l1 | pend_l2 | pend_l3 | pend_l4 | pend_l5;
            if (pend_l1) begin
                next.irq_vector = `PWK_VEC_L1;
            end else if (pend_l2) begin
                next.irq_vector = `PWK_VEC_L2;
            end else if (pend_l3) begin
                next.irq_vector = `PWK_VEC_L3;
            end else if (pend_l4) begin
                next.irq_vector = `PWK_VEC_L4;
            end else if (pend_l5) begin
                next.irq_vector = `PWK_VEC_L5;
            end
        end

        case (q.mode)
            PWK_RUN: begin
                if (sleep_instruction) begin
                    next.mode = q.cpu_mode[`PWK_CM_IDLE] ? PWK_IDLE : PWK_SLEEP;
                end
            end
            PWK_SLEEP: begin
                if (wake_sleep) begin
                    next.mode = PWK_RUN;
                end
            end
            PWK_IDLE: begin
                if (wake_idle) begin
                    next.mode = PWK_RUN;
                end
            end
            default: next.mode = PWK_RUN;
        endcase
        next.core_run = (next.mode == PWK_RUN);

        // slow to fast waits for oscillator edges
        next.fast_d = q.cpu_mode[`PWK_CM_FAST];
        if (!q.cpu_mode[`PWK_CM_FAST]) begin
            next.pll_select = 1'b0;
            next.switching = 1'b0;
        end else if (!q.fast_d && !q.pll_select) begin
            next.switching = 1'b1;
            next.switch_cnt = 4'h0;
        end else if (q.switching && osc_edge) begin
            next.switch_cnt = q.switch_cnt + 4'h1;
            if (q.switch_cnt == `PWK_SWITCH_OSC_CYCLES - 4'h1) begin
                next.pll_select = 1'b1;
                next.switching = 1'b0;
            end
        end

        if (!aresetn) begin
            next = '0;
            next.cpu_mode = `PWK_RST_BYTE;
            next.irq_en = `PWK_RST_BYTE;
            next.irq_flags = `PWK_RST_BYTE;
            next.core_run = 1'b1;
            next.touch_s1 = 1'b1;
            next.touch_s2 = 1'b1;
            next.awready = 1'b1;
            next.wready = 1'b1;
            next.arready = 1'b1;
            next.irq_vector = `PWK_VEC_RESET;
        end
    end

    always_ff @(posedge aclk) begin
        q <= next;
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;
    assign irq_req = q.irq_req;
    assign irq_vector = q.irq_vector;
    assign core_run = q.core_run;
    assign pll_select = q.pll_select;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_ack_global_off: assert property (
        q.irq_req && irq_ack |=> !q.cpu_mode[`PWK_CM_GLOBAL] && !q.irq_req ##1 !q.irq_req)
        else $error("global enable not cleared on acknowledge");
    chk_level1_vector: assert property (
        dispatch_ok && pend_l1 |=> q.irq_req && q.irq_vector == `PWK_VEC_L1)
        else $error("level 1 not dispatched to its vector");
    chk_level2_vector: assert property (
        dispatch_ok && !pend_l1 && pend_l2 |=> q.irq_req && q.irq_vector == `PWK_VEC_L2)
        else $error("level 2 not dispatched to its vector");
    chk_level4_vector: assert property (
        dispatch_ok && !pend_l1 && !pend_l2 && !pend_l3 && pend_l4
        |=> q.irq_vector == `PWK_VEC_L4)
        else $error("level 4 not dispatched to its vector");
    chk_level5_vector: assert property (
        dispatch_ok && !(pend_l1 || pend_l2 || pend_l3 || pend_l4) && pend_l5
        |=> q.irq_vector == `PWK_VEC_L5)
        else $error("level 5 not dispatched to its vector");
    chk_porta_fall_flag: assert property (
        q.pa_s3[0] && !q.pa_s2[0] |=> q.pa_flags[0])
        else $error("port A falling edge not flagged");
    chk_speech_reload: assert property (
        events.speech_tick && q.sph_count == 11'h000
        |=> q.sph_ctrl[`PWK_SPH_FLAG] && q.sph_count == $past({q.sph_ctrl[2:0], q.sph_reload}))
        else $error("speech timer underflow wrong");
    chk_timer1_reload: assert property (
        events.timer1_tick && q.t1_count == 8'h00
        |=> q.irq_flags[`PWK_IRQ_T1] && q.t1_count == $past(q.t1_reload))
        else $error("timer 1 underflow wrong");
    chk_pll_after_edges: assert property (
        $rose(q.pll_select) |-> $past(q.switch_cnt) == `PWK_SWITCH_OSC_CYCLES - 4'h1)
        else $error("clock switched early or late");
    chk_vector_area: assert property (
        q.irq_vector <= `PWK_VEC_LAST)
        else $error("vector outside vector area");
    chk_asleep_no_dispatch: assert property (
        q.mode != PWK_RUN && !q.irq_req |=> !q.irq_req)
        else $error("dispatch while asleep");
    chk_sleep_entry: assert property (
        q.mode == PWK_RUN && sleep_instruction
        |=> q.mode == ($past(q.cpu_mode[`PWK_CM_IDLE]) ? PWK_IDLE : PWK_SLEEP) && !q.core_run)
        else $error("wrong low power mode entered");

    cov_level1_taken: cover property (q.irq_req && irq_ack && q.irq_vector == `PWK_VEC_L1);
    cov_wake_sleep: cover property (q.mode == PWK_SLEEP ##1 q.mode == PWK_RUN);
    cov_clock_switch: cover property ($rose(q.pll_select));

endmodule

// file: pwk_defs.svh
`ifndef PWK_DEFS_SVH
`define PWK_DEFS_SVH

// register indices, byte address is four times the index
`define PWK_IDX_CPU_MODE      8'h0E
`define PWK_IDX_T2_RELOAD     8'h10
`define PWK_IDX_IRQ_EN        8'h22
`define PWK_IDX_IRQ_FLAGS     8'h23
`define PWK_IDX_T0_RELOAD_LO  8'h24
`define PWK_IDX_T0_RELOAD_HI  8'h25
`define PWK_IDX_T1_RELOAD     8'h26
`define PWK_IDX_PA_EN         8'h2D
`define PWK_IDX_PA_FLAGS      8'h2E
`define PWK_IDX_PA_WAKE       8'h2F
`define PWK_IDX_SPI_STAT      8'h40
`define PWK_IDX_SPH_CTRL      8'h49
`define PWK_IDX_SPH_RELOAD    8'h4A
`define PWK_IDX_WAKE_CTRL     8'h60

// cpu mode control fields
`define PWK_CM_FAST           0
`define PWK_CM_IDLE           1
`define PWK_CM_GLOBAL         2
`define PWK_CM_PLL_EN         7

// irq enable and flag positions
`define PWK_IRQ_T0            0
`define PWK_IRQ_T1            1
`define PWK_IRQ_T2            2
`define PWK_IRQ_UERR          3
`define PWK_IRQ_UTX           4
`define PWK_IRQ_URX           5
`define PWK_IRQ_ADC           6
`define PWK_IRQ_CAP           7

// spi status, speech control and wake control fields
`define PWK_SPI_WAKE          3
`define PWK_SPI_FLAG          4
`define PWK_SPI_EN            5
`define PWK_SPH_EN            4
`define PWK_SPH_FLAG          5
`define PWK_WK_T1             0
`define PWK_WK_ADC            1
`define PWK_WK_TOUCH          2
`define PWK_WK_SPI_SLAVE      3
`define PWK_WK_CAP_LO         4
`define PWK_WK_CAP_HI         5

// vector word addresses
`define PWK_VEC_RESET         20'h00000
`define PWK_VEC_L1            20'h00002
`define PWK_VEC_L2            20'h00004
`define PWK_VEC_L3            20'h00006
`define PWK_VEC_L4            20'h00008
`define PWK_VEC_L5            20'h0000A
`define PWK_VEC_LAST          20'h0000B

`define PWK_RST_BYTE          8'h00
`define PWK_SWITCH_OSC_CYCLES 4'h8
`define PWK_RESP_OKAY         2'h0
`define PWK_RESP_SLVERR       2'h2

`endif

// file: pwk_pkg.sv
package pwk_pkg;

    typedef enum logic [1:0] {PWK_RUN, PWK_SLEEP, PWK_IDLE} pwk_mode_type;

    typedef struct packed {
        logic adc_done;
        logic uart_error;
        logic uart_tx_empty;
        logic uart_rx_full;
        logic spi_rx_full;
        logic timer0_tick;
        logic timer1_tick;
        logic timer2_tick;
        logic speech_tick;
    } pwk_event_type;

    typedef struct packed {
        pwk_mode_type mode;
        logic         core_run;
        logic [7:0]   cpu_mode;
        logic [7:0]   irq_en;
        logic [7:0]   irq_flags;
        logic [7:0]   t2_reload;
        logic [7:0]   t0_lo;
        logic [7:0]   t0_hi;
        logic [7:0]   t1_reload;
        logic [7:0]   pa_en;
        logic [7:0]   pa_flags;
        logic [7:0]   pa_wake;
        logic [7:0]   spi_stat;
        logic [7:0]   sph_ctrl;
        logic [7:0]   sph_reload;
        logic [7:0]   wake_ctrl;
        logic [15:0]  t0_count;
        logic [7:0]   t1_count;
        logic [7:0]   t2_count;
        logic [10:0]  sph_count;
        logic [7:0]   pa_s1;
        logic [7:0]   pa_s2;
        logic [7:0]   pa_s3;
        logic         touch_s1;
        logic         touch_s2;
        logic         cap_s1;
        logic         cap_s2;
        logic         cap_s3;
        logic         osc_s1;
        logic         osc_s2;
        logic         osc_s3;
        logic         fast_d;
        logic         switching;
        logic [3:0]   switch_cnt;
        logic         pll_select;
        logic         irq_req;
        logic [19:0]  irq_vector;
        logic         awready;
        logic         wready;
        logic         arready;
        logic         bvalid;
        logic         rvalid;
        logic         aw_held;
        logic         w_held;
        logic [11:0]  aw_addr;
        logic [7:0]   wbyte;
        logic         wlane0;
        logic [1:0]   bresp;
        logic [1:0]   rresp;
        logic [31:0]  rdata;
    } pwk_state_type;

endpackage

// file: pwk_core_model.sv
`timescale 1ns/1ps
module pwk_core_model (
    input  wire logic aclk,
    input  wire logic irq_req,
    output logic      irq_ack
);
    initial irq_ack = 1'b0;
    always @(posedge aclk) irq_ack <= irq_req & ~irq_ack;
endmodule

// file: priority_interrupt_wakeup_test.sv
`timescale 1ns/1ps
module priority_interrupt_wakeup_test import pwk_pkg::*;;
    logic          aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready;
    logic          bvalid, arready, rvalid, touch_request_n, capture_pin, osc_clock_pin;
    logic          sleep_instruction, irq_ack, irq_req, core_run, pll_select;
    logic [1:0]    bresp, rresp, r;
    logic [3:0]    wstrb;
    logic [7:0]    porta_pin, d;
    logic [11:0]   awaddr, araddr;
    logic [19:0]   irq_vector;
    logic [31:0]   wdata, rdata;
    pwk_event_type events;
    int            errors, check_count;
    pwk_ctrl dut_u (.*);
    pwk_core_model core_u (.*);
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic chk(input string nm, input logic [19:0] e, input logic [19:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        logic ta, tw, tb;
        tb = 1'b0;
        awaddr <= a;
        wdata <= {24'h000000, v};
        {awvalid, wvalid} <= 2'h3;
        while (!tb) begin
            @(negedge aclk);
            {ta, tw, tb, r} = {awready, wready, bvalid, bresp};
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end
    endtask
    task automatic rd(input logic [11:0] a);
        logic ta, tb;
        tb = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        while (!tb) begin
            @(negedge aclk);
            {ta, tb, d, r} = {arready, rvalid, rdata[7:0], rresp};
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
    endtask
    task automatic lvl(input logic [11:0] ea, input logic [7:0] ev, input logic [8:0] ep,
                       input logic [7:0] pp, input logic [11:0] ca, input logic [7:0] cv,
                       input logic [19:0] vec);
        wr(ea, ev);
        events <= ep;
        porta_pin <= pp;
        @(posedge aclk);
        events <= '0;
        repeat (6) @(posedge aclk);
        porta_pin <= 8'hFF;
        wr(12'h038, 8'h04);
        repeat (4) @(posedge aclk);
        chk("irq_vector", vec, irq_vector);
        rd(12'h038);
        chk("global", 20'h0, 20'(d[2]));
        wr(ca, cv);
        $display("test %h done", vec);
    endtask
    task automatic nap(input logic [8:0] ep, input logic [7:0] pp, input logic ew);
        sleep_instruction <= 1'b1;
        @(posedge aclk);
        sleep_instruction <= 1'b0;
        @(posedge aclk);
        chk("core_run", 20'h0, 20'(core_run));
        events <= ep;
        porta_pin <= pp;
        @(posedge aclk);
        events <= '0;
        repeat (6) @(posedge aclk);
        porta_pin <= 8'hFF;
        chk("core_run", 20'(ew), 20'(core_run));
        $display("test nap %h done", ep);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #300000;
        errors++;
        give_verdict();
    end
    initial begin
        {aresetn, awvalid, wvalid, arvalid, osc_clock_pin, sleep_instruction} = '0;
        {bready, rready, touch_request_n, capture_pin} = 4'hF;
        {awaddr, araddr, wdata, events} = '0;
        wstrb = 4'hF;
        porta_pin = 8'hFF;
        errors = 0;
        check_count = 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("irq_vector", 20'h00000, irq_vector);
        rd(12'h004);
        chk("rresp", 20'h2, 20'(r));
        wr(12'h004, 8'h00);
        chk("bresp", 20'h2, 20'(r));
        lvl(12'h0B4, 8'h01, 9'h000, 8'hFE, 12'h0B8, 8'h00, 20'h00002);
        lvl(12'h124, 8'h10, 9'h001, 8'hFF, 12'h124, 8'h00, 20'h00006);
        lvl(12'h088, 8'h04, 9'h002, 8'hFF, 12'h08C, 8'h00, 20'h00008);
        lvl(12'h088, 8'h40, 9'h100, 8'hFF, 12'h08C, 8'h00, 20'h0000A);
        lvl(12'h088, 8'h0A, 9'h084, 8'hFF, 12'h08C, 8'h08, 20'h00008);
        lvl(12'h088, 8'h0A, 9'h000, 8'hFF, 12'h08C, 8'h00, 20'h0000A);
        lvl(12'h100, 8'h20, 9'h010, 8'hFF, 12'h100, 8'h00, 20'h0000A);
        events <= 9'h008;
        lvl(12'h088, 8'h01, 9'h008, 8'hFF, 12'h08C, 8'h00, 20'h00008);
        touch_request_n <= 1'b0;
        lvl(12'h180, 8'h04, 9'h000, 8'hFF, 12'h180, 8'h00, 20'h00002);
        touch_request_n <= 1'b1;
        capture_pin <= 1'b0;
        lvl(12'h088, 8'h80, 9'h000, 8'hFF, 12'h08C, 8'h00, 20'h00004);
        wr(12'h0BC, 8'h01);
        wr(12'h180, 8'h01);
        nap(9'h004, 8'hFF, 1'b0);
        nap(9'h000, 8'hFE, 1'b1);
        wr(12'h0B8, 8'h00);
        wr(12'h08C, 8'h00);
        wr(12'h038, 8'h02);
        nap(9'h004, 8'hFF, 1'b1);
        wr(12'h038, 8'h01);
        for (int i = 1; i <= 8; i++) begin
            osc_clock_pin <= 1'b1;
            repeat (4) @(posedge aclk);
            osc_clock_pin <= 1'b0;
            repeat (4) @(posedge aclk);
            chk("pll_select", 20'(i == 8), 20'(pll_select));
        end
        $display("test clock switch done");
        give_verdict();
    end
endmodule
